// ---- rtl/energy_pulse_output_ctrl.sv ----
// Energy-to-pulse converter with strap configuration and bus registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Rate strap selects both pulse format and full-scale pulse rate.
// - Selects 1-5 stepper 0.25-4 Hz; selects 6,7 counter 2 and 16 Hz.
// - Full-scale rate only at full scale; scales with channel fraction product.
// - Stepper pulses alternate between outputs a and b, active low.
// - Stepper width 250 ms, or 125 ms for the 4 Hz option.
// - Counter pulses active low, 125 ms or 15 ms by rate.
// - Counter pulses on a for positive energy, on b for negative.
// - Direction flag refreshed once per converter sample.
// - Flag low on negative energy, held until positive energy returns.
// - Startup scans both trim straps and sets gain correction.
// - Coarse trim +4.2 to -4.2 percent, fine +0.6 to -0.6 percent.
// - Sum of trims scales all outputs, 0.2 percent steps, 49 settings.
// - Supply below 2.5 V puts the block in reset.
// - Reset held until 4 V, then straps rescanned and pulsing resumes.
// - Calibration output averages 10 kHz at full scale, same scaling.
// - After the scan straps are plain inputs and conversion begins.
module energy_pulse_output_ctrl import epo_pkg::*; #(
  parameter int PW = 16,
  parameter int LONG_CYC = CYC_LONG,
  parameter int MID_CYC = CYC_MID,
  parameter int SHORT_CYC = CYC_SHORT,
  parameter int TICK_DIV = TICK_CYC,
  parameter int SETTLE = SCAN_SETTLE_CYC
) (
  input wire logic clk, // Master clock, 40 MHz.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic [3:0] address, // Avalon byte address.
  input wire logic read, // Avalon read.
  input wire logic write, // Avalon write.
  input wire logic [31:0] writedata, // Avalon write data.
  output logic [31:0] readdata, // Avalon read data.
  output logic waitrequest, // Avalon wait.
  input wire logic sample_valid, // New power sample.
  input wire logic signed [PW-1:0] sample_power, // Signed power, full scale max.
  input wire logic supply_low_pin, // Supply below 2.5 V.
  input wire logic supply_ok_pin, // Supply at least 4 V.
  input wire logic rate_select_strap, // Rate strap pin.
  input wire logic coarse_trim_strap, // Coarse trim strap pin.
  input wire logic fine_trim_strap, // Fine trim strap pin.
  output logic [NSEL-1:0] program_select_outputs, // Scan drive lines.
  output logic energy_pulse_a_n, // Low-rate pulse a, active low.
  output logic energy_pulse_b_n, // Low-rate pulse b, active low.
  output logic reverse_energy_flag_n, // Low while energy is negative.
  output logic calibration_pulse_out // High-rate pulse, one cycle high.
);

  localparam longint FS = (longint'(1) << (PW - 1)) - 1;
  localparam logic [47:0] CAL_T = 48'(FS * GAIN_ONE * TICK_HZ / CAL_HZ);
  localparam int SPW = PW + 11;

  function automatic logic signed [47:0] low_thresh(input logic [2:0] sel);
    low_thresh = 48'(FS * GAIN_ONE * TICK_HZ * 4 / rate_qhz(sel));
  endfunction : low_thresh

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [4:0] pin_s1_ff;
  logic [4:0] pin_s2_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_ff <= 5'h00;
      pin_s2_ff <= 5'h00;
    end else begin
      pin_s1_ff <= {supply_ok_pin, supply_low_pin, fine_trim_strap,
                    coarse_trim_strap, rate_select_strap};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Supply hold and scan requests.

  logic brown_ff, nxt_brown;
  logic scan_pend_ff, nxt_scan_pend;
  logic rescan_wr;
  logic scan_start;

  always_comb begin
    nxt_brown = brown_ff;
    if (pin_s2_ff[3]) begin
      nxt_brown = 1'b1;
    end else if (pin_s2_ff[4]) begin
      nxt_brown = 1'b0;
    end
    nxt_scan_pend = brown_ff | rescan_wr;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      brown_ff <= 1'b0;
      scan_pend_ff <= 1'b1;
    end else begin
      brown_ff <= nxt_brown;
      scan_pend_ff <= nxt_scan_pend;
    end
  end

  assign scan_start = scan_pend_ff & ~brown_ff;

  logic scan_done;
  logic [2:0][2:0] sel_idx;
  logic [2:0] scan_err;

  strap_scanner #(.SETTLE(SETTLE)) u_scan (
    .clk(clk),
    .rst_b(rst_b),
    .clear(brown_ff),
    .start(scan_start),
    .strap(pin_s2_ff[2:0]),
    .sel_out(program_select_outputs),
    .done(scan_done),
    .idx(sel_idx),
    .err(scan_err)
  );

  logic [2:0] rate_sel;
  logic counter_mode;
  logic [9:0] gain_w;
  logic [31:0] width_w;

  assign rate_sel = sel_idx[0];
  assign counter_mode = is_counter(rate_sel);
  assign gain_w = trim_gain(sel_idx[1], sel_idx[2]);

  always_comb begin
    if (counter_mode) begin
      width_w = (rate_sel == SEL_CNT_2HZ) ? 32'(MID_CYC) : 32'(SHORT_CYC);
    end else begin
      width_w = (rate_sel == SEL_STEP_4HZ) ? 32'(MID_CYC) : 32'(LONG_CYC);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register slave: one wait cycle, then the answer.

  logic ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic en_ff, nxt_en;
  logic [31:0] cnt_ff, nxt_cnt;
  logic fire_a, fire_b;
  logic neg_ff;
  logic wr_go;

  assign wr_go = write & ack_ff;
  assign rescan_wr = wr_go & (address == REG_CTRL) & writedata[CTRL_RESCAN_BIT];

  always_comb begin
    nxt_ack = (read | write) & ~ack_ff;
    nxt_rdata = rdata_ff;
    nxt_en = en_ff;
    nxt_cnt = cnt_ff;
    if (read && !ack_ff) begin
      nxt_rdata = 32'h0;
      case (address)
        REG_CTRL: nxt_rdata[CTRL_EN_BIT] = en_ff;
        REG_STATUS: begin
          nxt_rdata[ST_DONE_BIT] = scan_done;
          nxt_rdata[ST_BROWN_BIT] = brown_ff;
          nxt_rdata[ST_ERR_POS +: 3] = scan_err;
          nxt_rdata[ST_RATE_POS +: 3] = sel_idx[0];
          nxt_rdata[ST_COARSE_POS +: 3] = sel_idx[1];
          nxt_rdata[ST_FINE_POS +: 3] = sel_idx[2];
          nxt_rdata[ST_REV_BIT] = neg_ff;
        end
        REG_COUNT: nxt_rdata = cnt_ff;
        default: nxt_rdata = 32'h0;
      endcase
    end
    if (wr_go && address == REG_CTRL) begin
      nxt_en = writedata[CTRL_EN_BIT];
    end
    if (wr_go && address == REG_COUNT) begin
      nxt_cnt = 32'h0;
    end
    if (fire_a || fire_b) begin
      nxt_cnt = nxt_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0;
      en_ff <= CTRL_EN_RST;
      cnt_ff <= 32'h0;
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
      en_ff <= nxt_en;
      cnt_ff <= nxt_cnt;
    end
  end

  assign waitrequest = (read | write) & ~ack_ff;
  assign readdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // Energy integration and pulse events.

  logic run;
  logic tick;
  logic [15:0] tick_ff, nxt_tick;
  logic signed [PW-1:0] pwr_ff, nxt_pwr;
  logic nxt_neg;
  logic signed [47:0] acc_ff, nxt_acc, acc_sum, low_t;
  logic [47:0] cal_acc_ff, nxt_cal_acc;
  logic cal_ff, nxt_cal;
  logic side_ff, nxt_side;
  logic signed [SPW-1:0] sp;
  logic [SPW-1:0] sp_abs;
  logic ev_pos, ev_neg, ev_any;

  assign run = scan_done & ~brown_ff & en_ff;
  assign tick = run & (tick_ff == 16'(TICK_DIV - 1));
  assign sp = pwr_ff * $signed({1'b0, gain_w});
  assign sp_abs = sp[SPW-1] ? SPW'(-sp) : SPW'(sp);
  assign low_t = low_thresh(rate_sel);
  assign acc_sum = acc_ff + 48'(sp);
  assign ev_pos = tick & (acc_sum >= low_t);
  assign ev_neg = tick & (acc_sum <= -low_t);
  assign ev_any = ev_pos | ev_neg;
  assign fire_a = counter_mode ? ev_pos : (ev_any & ~side_ff);
  assign fire_b = counter_mode ? ev_neg : (ev_any & side_ff);

  always_comb begin
    nxt_tick = run ? ((tick_ff == 16'(TICK_DIV - 1)) ? 16'h0 : tick_ff + 16'h1) : 16'h0;
    nxt_pwr = sample_valid ? sample_power : pwr_ff;
    nxt_neg = neg_ff;
    if (run && sample_valid && sample_power < 0) begin
      nxt_neg = 1'b1;
    end else if (run && sample_valid && sample_power > 0) begin
      nxt_neg = 1'b0;
    end
    nxt_acc = acc_ff;
    nxt_cal_acc = cal_acc_ff;
    nxt_cal = 1'b0;
    nxt_side = side_ff ^ (ev_any & ~counter_mode);
    if (tick) begin
      nxt_acc = ev_pos ? acc_sum - low_t : ev_neg ? acc_sum + low_t : acc_sum;
      nxt_cal_acc = cal_acc_ff + 48'(sp_abs);
      if (nxt_cal_acc >= CAL_T) begin
        nxt_cal_acc = nxt_cal_acc - CAL_T;
        nxt_cal = 1'b1;
      end
    end
    if (brown_ff) begin
      nxt_neg = 1'b0;
      nxt_acc = 48'h0;
      nxt_cal_acc = 48'h0;
      nxt_side = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_ff <= 16'h0;
      pwr_ff <= '0;
      neg_ff <= 1'b0;
      acc_ff <= 48'h0;
      cal_acc_ff <= 48'h0;
      cal_ff <= 1'b0;
      side_ff <= 1'b0;
    end else begin
      tick_ff <= nxt_tick;
      pwr_ff <= nxt_pwr;
      neg_ff <= nxt_neg;
      acc_ff <= nxt_acc;
      cal_acc_ff <= nxt_cal_acc;
      cal_ff <= nxt_cal;
      side_ff <= nxt_side;
    end
  end

  assign reverse_energy_flag_n = ~neg_ff;
  assign calibration_pulse_out = cal_ff;

  logic a_busy, b_busy;

  pulse_stretcher u_pa (
    .clk(clk),
    .rst_b(rst_b),
    .clear(brown_ff),
    .fire(fire_a),
    .width_cyc(width_w),
    .pulse_n(energy_pulse_a_n),
    .busy(a_busy)
  );

  pulse_stretcher u_pb (
    .clk(clk),
    .rst_b(rst_b),
    .clear(brown_ff),
    .fire(fire_b),
    .width_cyc(width_w),
    .pulse_n(energy_pulse_b_n),
    .busy(b_busy)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  logic [31:0] a_len_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      a_len_ff <= 32'h0;
    end else begin
      a_len_ff <= energy_pulse_a_n ? 32'h0 : a_len_ff + 32'h1;
    end
  end

  AST_SCAN_ONEHOT: assert property (@(posedge clk) disable iff (!rst_b)
    $onehot0(program_select_outputs)) else $error("select outputs not one-hot");
  AST_WIDTH_A: assert property (@(posedge clk) disable iff (!rst_b || brown_ff)
    $rose(energy_pulse_a_n) |-> a_len_ff == width_w) else $error("pulse a width wrong");
  AST_STEP_ALT: assert property (@(posedge clk) disable iff (!rst_b)
    !counter_mode && ev_any && !side_ff && !a_busy |=> $fell(energy_pulse_a_n))
    else $error("stepper pulse a missing");
  AST_CNT_POS: assert property (@(posedge clk) disable iff (!rst_b)
    counter_mode && ev_pos && !a_busy && !b_busy |=> $fell(energy_pulse_a_n) &&
    !$fell(energy_pulse_b_n))
    else $error("counter positive pulse missing");
  AST_CNT_NEG: assert property (@(posedge clk) disable iff (!rst_b)
    counter_mode && ev_neg && !b_busy && !a_busy |=> $fell(energy_pulse_b_n) &&
    !$fell(energy_pulse_a_n))
    else $error("counter negative pulse missing");
  AST_NEG_SET: assert property (@(posedge clk) disable iff (!rst_b)
    run && sample_valid && sample_power < 0 |=> !reverse_energy_flag_n)
    else $error("direction flag not set");
  AST_NEG_HOLD: assert property (@(posedge clk) disable iff (!rst_b || brown_ff)
    !(sample_valid && sample_power != 0) |=> $stable(reverse_energy_flag_n))
    else $error("direction flag moved without sample");
  AST_BROWN: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(brown_ff) |=> energy_pulse_a_n && energy_pulse_b_n && program_select_outputs == '0)
    else $error("outputs active in supply hold");
  AST_RESCAN: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(brown_ff) |-> ##[1:3] program_select_outputs != '0) else $error("no rescan");
  AST_TRIM_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
    sel_idx[1] == DEF_SEL && sel_idx[2] == DEF_SEL |-> gain_w == 10'(GAIN_ONE))
    else $error("zero trim gain wrong");
  AST_CAL_TICK: assert property (@(posedge clk) disable iff (!rst_b)
    calibration_pulse_out |-> $past(tick)) else $error("calibration pulse off tick");

  COV_STEP: cover property (@(posedge clk) !counter_mode && $fell(energy_pulse_b_n));
  COV_CNT_NEG: cover property (@(posedge clk) counter_mode && $fell(energy_pulse_b_n));
  COV_SCAN: cover property (@(posedge clk) $rose(scan_done));
  COV_BROWN: cover property (@(posedge clk) $fell(brown_ff));

endmodule : energy_pulse_output_ctrl
`default_nettype wire

// ---- rtl/epo_pkg.sv ----
// Shared constants and decode functions for the energy pulse output block.
package epo_pkg;

  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_HZ = 100_000;
  localparam int TICK_CYC = CLK_HZ / TICK_HZ;
  localparam int CAL_HZ = 10_000;
  // Unity gain; one trim step of 0.2 percent is one unit.
  localparam int GAIN_ONE = 500;
  localparam int W_LONG_MS = 250;
  localparam int W_MID_MS = 125;
  localparam int W_SHORT_MS = 15;
  localparam int CYC_LONG = W_LONG_MS * (CLK_HZ / 1000);
  localparam int CYC_MID = W_MID_MS * (CLK_HZ / 1000);
  localparam int CYC_SHORT = W_SHORT_MS * (CLK_HZ / 1000);
  localparam int SCAN_SETTLE_CYC = 8;
  localparam int NSEL = 7;
  localparam logic [2:0] DEF_SEL = 3'h3;
  localparam logic [2:0] SEL_STEP_4HZ = 3'h4;
  localparam logic [2:0] SEL_CNT_2HZ = 3'h5;

  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_COUNT = 4'h8;
  localparam int CTRL_RESCAN_BIT = 0;
  localparam int CTRL_EN_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_BROWN_BIT = 1;
  localparam int ST_ERR_POS = 2;
  localparam int ST_RATE_POS = 8;
  localparam int ST_COARSE_POS = 12;
  localparam int ST_FINE_POS = 16;
  localparam int ST_REV_BIT = 20;

  // Full-scale rate in quarter hertz for each select line.
  function automatic int rate_qhz(input logic [2:0] sel);
    case (sel)
      3'h0: rate_qhz = 1;
      3'h1: rate_qhz = 2;
      3'h2: rate_qhz = 4;
      3'h3: rate_qhz = 8;
      3'h4: rate_qhz = 16;
      3'h5: rate_qhz = 8;
      default: rate_qhz = 64;
    endcase
  endfunction : rate_qhz

  function automatic logic is_counter(input logic [2:0] sel);
    is_counter = (sel >= SEL_CNT_2HZ);
  endfunction : is_counter

  // Gain in 0.2 percent units: coarse 7 steps apart, fine 1 step apart.
  function automatic logic [9:0] trim_gain(input logic [2:0] c, input logic [2:0] f);
    trim_gain = 10'(GAIN_ONE + (3 - int'(c)) * 7 + (3 - int'(f)));
  endfunction : trim_gain

endpackage : epo_pkg

// ---- rtl/pulse_stretcher.sv ----
// Stretches a one-cycle event into an active-low pulse of set width.
`timescale 1ns/1ps
`default_nettype none
module pulse_stretcher (
  input wire logic clk, // Master clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic clear, // Forces the output idle.
  input wire logic fire, // One-cycle event.
  input wire logic [31:0] width_cyc, // Low time in clock cycles.
  output logic pulse_n, // Active-low pulse.
  output logic busy // Pulse running or one event waiting.
);

  logic [31:0] cnt_ff, nxt_cnt;
  logic low_ff, nxt_low;
  logic pend_ff, nxt_pend;

  // One event can wait; a one-cycle high gap separates pulses.
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_low = low_ff;
    nxt_pend = pend_ff;
    if (clear) begin
      nxt_cnt = 32'h0;
      nxt_low = 1'b0;
      nxt_pend = 1'b0;
    end else if (cnt_ff != 32'h0) begin
      nxt_cnt = cnt_ff - 32'h1;
      nxt_low = (cnt_ff != 32'h1);
      nxt_pend = pend_ff | fire;
    end else if (fire || pend_ff) begin
      nxt_cnt = width_cyc;
      nxt_low = 1'b1;
      nxt_pend = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 32'h0;
      low_ff <= 1'b0;
      pend_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      low_ff <= nxt_low;
      pend_ff <= nxt_pend;
    end
  end

  assign pulse_n = ~low_ff;
  assign busy = low_ff | pend_ff;

endmodule : pulse_stretcher
`default_nettype wire

// ---- rtl/strap_scanner.sv ----
// Startup scan that finds which select output each strap input follows.
`timescale 1ns/1ps
`default_nettype none
module strap_scanner import epo_pkg::*; #(
  parameter int SETTLE = SCAN_SETTLE_CYC
) (
  input wire logic clk, // Master clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic clear, // Supply-monitor hold.
  input wire logic start, // Begin a scan.
  input wire logic [2:0] strap, // Synchronised rate, coarse, fine straps.
  output logic [NSEL-1:0] sel_out, // Select outputs, one high at a time.
  output logic done, // Scan results valid.
  output logic [2:0][2:0] idx, // Select index per strap.
  output logic [2:0] err // Strap not tied to exactly one select.
);

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_DRIVE = 2'b01,
    S_DONE = 2'b10
  } scan_state_e;

  scan_state_e st_ff, nxt_st;
  logic [2:0] pos_ff, nxt_pos;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [NSEL-1:0] sel_ff, nxt_sel;
  logic [2:0][1:0] hits_ff, nxt_hits;
  logic [2:0][2:0] idx_ff, nxt_idx;
  logic [2:0] err_ff, nxt_err;
  logic done_ff, nxt_done;

  always_comb begin
    nxt_st = st_ff;
    nxt_pos = pos_ff;
    nxt_cnt = cnt_ff;
    nxt_sel = sel_ff;
    nxt_hits = hits_ff;
    nxt_idx = idx_ff;
    nxt_err = err_ff;
    nxt_done = done_ff;
    case (st_ff)
      S_IDLE: begin
        if (start) begin
          nxt_st = S_DRIVE;
          nxt_pos = 3'h0;
          nxt_cnt = 8'h00;
          nxt_sel = NSEL'(1);
          nxt_hits = '0;
          nxt_done = 1'b0;
        end
      end
      S_DRIVE: begin
        nxt_cnt = cnt_ff + 8'h01;
        if (cnt_ff == 8'(SETTLE - 1)) begin
          nxt_cnt = 8'h00;
          for (int i = 0; i < 3; i++) begin
            if (strap[i]) begin
              nxt_idx[i] = pos_ff;
              nxt_hits[i] = (hits_ff[i] == 2'h3) ? 2'h3 : hits_ff[i] + 2'h1;
            end
          end
          if (pos_ff == 3'(NSEL - 1)) begin
            nxt_st = S_DONE;
            nxt_sel = '0;
          end else begin
            nxt_pos = pos_ff + 3'h1;
            nxt_sel = sel_ff << 1;
          end
        end
      end
      S_DONE: begin
        for (int i = 0; i < 3; i++) begin
          nxt_err[i] = (hits_ff[i] != 2'h1);
          if (hits_ff[i] != 2'h1) begin
            nxt_idx[i] = DEF_SEL;
          end
        end
        nxt_done = 1'b1;
        nxt_st = S_IDLE;
      end
      default: nxt_st = S_IDLE;
    endcase
    if (clear) begin
      nxt_st = S_IDLE;
      nxt_sel = '0;
      nxt_done = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= S_IDLE;
      pos_ff <= 3'h0;
      cnt_ff <= 8'h00;
      sel_ff <= '0;
      hits_ff <= '0;
      idx_ff <= {DEF_SEL, DEF_SEL, DEF_SEL};
      err_ff <= 3'h0;
      done_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      pos_ff <= nxt_pos;
      cnt_ff <= nxt_cnt;
      sel_ff <= nxt_sel;
      hits_ff <= nxt_hits;
      idx_ff <= nxt_idx;
      err_ff <= nxt_err;
      done_ff <= nxt_done;
    end
  end

  assign sel_out = sel_ff;
  assign done = done_ff;
  assign idx = idx_ff;
  assign err = err_ff;

endmodule : strap_scanner
`default_nettype wire

// ---- sim/strap_board.sv ----
// Board wiring of the straps and a two-way counter on the pulse outputs.
`timescale 1ns/1ps
`default_nettype none
module strap_board (
  input wire logic [6:0] sel, // Select outputs of the block.
  input wire logic [2:0] rate_idx, // Select line wired to the rate strap.
  input wire logic [2:0] coarse_idx, // Select line wired to the coarse strap.
  input wire logic [2:0] fine_idx, // Select line wired to the fine strap.
  input wire logic pa_n, // Pulse output a.
  input wire logic pb_n, // Pulse output b.
  output logic rate_s, // Rate strap pin.
  output logic coarse_s, // Coarse strap pin.
  output logic fine_s, // Fine strap pin.
  output int tally // Counter reading, up on a and down on b.
);
  ////////////////////////////////////////////////////////////////////////////
  // Each strap follows exactly one select line, so it reads low between scans.
  assign rate_s = sel[rate_idx];
  assign coarse_s = sel[coarse_idx];
  assign fine_s = sel[fine_idx];
  ////////////////////////////////////////////////////////////////////////////
  logic pa_q = 1'b1;
  logic pb_q = 1'b1;
  int count_q = 0;
  // One process keeps the reading, so a fall on a counts up and a fall on b counts down.
  always @(pa_n or pb_n) begin
    if (pa_q === 1'b1 && pa_n === 1'b0) count_q = count_q + 1;
    if (pb_q === 1'b1 && pb_n === 1'b0) count_q = count_q - 1;
    pa_q = pa_n;
    pb_q = pb_n;
  end
  assign tally = count_q;
endmodule : strap_board
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for the energy pulse output block.
`timescale 1ns/1ps
`default_nettype none
module tb_top import epo_pkg::*;;
  localparam int MID = 20;
  localparam int SHORT = 6;
  logic clk = 0, rst_b = 0, read = 0, write = 0, sample_valid = 0;
  logic supply_low_pin = 0, supply_ok_pin = 1, side, rs, cs, fs, pa_n, pb_n, flag_n, cal;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata, rd, lfsr = 32'haee183a5;
  logic waitrequest;
  logic signed [15:0] sample_power = 16'sh0000;
  logic [6:0] sel;
  logic [2:0] ri = 3'h4, ci = 3'h0, fi = 3'h0;
  int fails = 0, n_checks = 0, cyc = 0, tally, w, t0, e, n_cal = 0;
  ////////////////////////////////////////////////////////////////////////////
  energy_pulse_output_ctrl #(.LONG_CYC(40), .MID_CYC(MID), .SHORT_CYC(SHORT), .TICK_DIV(1),
    .SETTLE(4)) energy_pulse_output_ctrl_inst (.clk(clk), .rst_b(rst_b), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .sample_valid(sample_valid), .sample_power(sample_power),
    .supply_low_pin(supply_low_pin), .supply_ok_pin(supply_ok_pin), .rate_select_strap(rs),
    .coarse_trim_strap(cs), .fine_trim_strap(fs), .program_select_outputs(sel),
    .energy_pulse_a_n(pa_n), .energy_pulse_b_n(pb_n), .reverse_energy_flag_n(flag_n),
    .calibration_pulse_out(cal));
  strap_board strap_board_inst (.sel(sel), .rate_idx(ri), .coarse_idx(ci), .fine_idx(fi),
    .pa_n(pa_n), .pb_n(pb_n), .rate_s(rs), .coarse_s(cs), .fine_s(fs), .tally(tally));
  ////////////////////////////////////////////////////////////////////////////
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sample_valid <= (cyc % 4 == 0);
    if (cal === 1'b1) n_cal <= n_cal + 1;
    if (cyc == 90000) begin
      fails++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  // Gain in 0.2 percent units for a coarse and fine select index.
  function automatic int gain_units(input int c, input int f);
    gain_units = 500 + (3 - c) * 7 + (3 - f);
  endfunction : gain_units
  // Ticks to the first 16 Hz counter pulse at full scale for a gain.
  function automatic int exp_ticks(input int g);
    exp_ticks = (500 * 6250 + g - 1) / g;
  endfunction : exp_ticks
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do @(posedge clk); while (waitrequest !== 1'b0 && n++ < 20);
    if (waitrequest !== 1'b0) fails++;
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task check_straps();
    int n;
    n = 0;
    repeat (10) @(posedge clk);
    do bus(0, REG_STATUS, 0, rd); while (rd[ST_DONE_BIT] !== 1'b1 && n++ < 200);
    chk("scan done", 1, 32'(rd[ST_DONE_BIT]));
    chk("rate idx", 32'(ri), 32'(rd[10:8]));
    chk("coarse idx", 32'(ci), 32'(rd[14:12]));
    chk("fine idx", 32'(fi), 32'(rd[18:16]));
    chk("strap errors", 0, 32'(rd[4:2]));
    chk("selects idle", 0, 32'(sel));
  endtask : check_straps
  task catch_pulse(output logic s, output int width, output int t);
    t = cyc;
    while (pa_n === 1'b1 && pb_n === 1'b1 && cyc - t < 60000) @(negedge clk);
    s = (pb_n === 1'b0);
    t = cyc - t;
    width = 0;
    while ((pa_n === 1'b0 || pb_n === 1'b0) && width < 100) begin
      @(negedge clk);
      width++;
    end
  endtask : catch_pulse
  task print_verdict();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    check_straps();
    bus(0, 4'hc, 0, rd);
    chk("unmapped read", 0, rd);
    @(posedge clk);
    sample_power <= 16'sd32767;
    catch_pulse(side, w, t0);
    chk("step first side", 0, 32'(side));
    chk("step width", MID, w);
    catch_pulse(side, w, t0);
    chk("step second side", 1, 32'(side));
    chk("step width", MID, w);
    e = n_cal;
    repeat (5000) @(posedge clk);
    w = n_cal - e;
    chk("cal pulses", 32'(gain_units(ci, fi)), 32'(w));
    bus(0, REG_COUNT, 0, rd);
    chk("pulse count", 2, rd);
    bus(1, REG_COUNT, 0, rd);
    bus(0, REG_COUNT, 0, rd);
    chk("count cleared", 0, rd);
    sample_power <= 16'sh0000;
    supply_low_pin <= 1'b1;
    supply_ok_pin <= 1'b0;
    repeat (10) @(posedge clk);
    bus(0, REG_STATUS, 0, rd);
    chk("supply hold", 1, 32'(rd[ST_BROWN_BIT]));
    chk("pulses idle", 3, 32'({pa_n, pb_n}));
    lfsr = lfsr_next(lfsr);
    ri <= 3'h6;
    ci <= lfsr[2:0] % 3'h7;
    fi <= lfsr[5:3] % 3'h7;
    supply_low_pin <= 1'b0;
    supply_ok_pin <= 1'b1;
    check_straps();
    @(posedge clk);
    sample_power <= 16'sd32767;
    catch_pulse(side, w, t0);
    chk("count side pos", 0, 32'(side));
    chk("count width", SHORT, w);
    chk("counter tally up", 1, 32'(tally));
    e = exp_ticks(gain_units(ci, fi));
    chk("pulse spacing", 1, 32'(t0 >= e - e / 50 && t0 <= e + e / 50 + 16));
    @(posedge clk);
    sample_power <= -16'sd16384 - 16'(lfsr[13:0]);
    repeat (10) @(negedge clk);
    chk("flag negative", 0, 32'(flag_n));
    catch_pulse(side, w, t0);
    chk("count side neg", 1, 32'(side));
    chk("count width", SHORT, w);
    chk("counter tally down", 0, 32'(tally));
    @(posedge clk);
    sample_power <= 16'sd32767;
    repeat (10) @(negedge clk);
    chk("flag positive", 1, 32'(flag_n));
    @(posedge clk);
    lfsr = lfsr_next(lfsr);
    ri <= 3'h5;
    fi <= lfsr[2:0] % 3'h7;
    bus(1, REG_CTRL, 32'h3, rd);
    check_straps();
    bus(0, REG_CTRL, 0, rd);
    chk("ctrl enable", 2, rd);
    bus(1, REG_CTRL, 0, rd);
    bus(0, REG_CTRL, 0, rd);
    chk("ctrl disable", 0, rd);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
